/* File: hw/afs_supervisor.sv */
/*
  Fault supervisor of a four-half-bridge class-D stage: startup pin short
  check, DC speaker check, overload, thermal, undervoltage and reset handling.
  Assumes all inputs are synchronous to i_mclk and the analog comparators
  arrive as levels; i_nrst is the power-on clear.
*/
// Operation
// (R1) DC imbalance drives overload counter to max, shutdown
// (R2) DC check off in paralleled and single-ended
// (R3) Pin short check only at power-up
// (R4) Short found: all bridges Hi-Z until gone
// (R5) Check ground shorts first, then supply shorts
// (R6) Check time scales with filter capacitance
// (R7) Alert low, reset ignored during check
// (R8) Reset cycle does not rerun the check
// (R9) Check runs bridged modes, skipped single-ended
// (R10) Heat warning low above warning threshold
// (R11) Thermal shutdown latches until reset
// (R12) Supply low: Hi-Z and alert, self-clears
// (R13) Power-on clear resets overload counters
// (R14) Global fault stops all, reset toggle clears
// (R15) Channel fault stops only its channel
// (R16) Reset low forces alert high
// (R17) Controller releases reset only without warning
// (R18) Slow slave clock: silent Hi-Z, self-recover
// (R19) Warning self-clears, outputs keep running
// (R20) Reset low ramps down, then Hi-Z
// (R21) Reset low enables output pull-downs
// (R22) Reset rising edge clears latched overload
// (R23) Controller waits 4 ms after alert fall; the host model waits GAP_CYC = 30 cycles
// (R24) Bootstrap low: high side off only
`include "afs_defines.svh"
`default_nettype none
module afs_supervisor
  import afs_pkg::*;
#(
  parameter int unsigned PSC_STEP_CYC = `AFS_PSC_STEP_CYC,
  parameter int unsigned RAMP_CYC = `AFS_RAMP_CYC
) (
  // Clock and power-on clear.
  input wire logic i_mclk,
  input wire logic i_nrst,
  // Controller reset pin.
  input wire logic i_reset_n,
  // Configuration.
  input wire logic [1:0] i_out_mode,
  input wire logic i_slave_clock_mode,
  input wire logic i_external_switch_clock_slow,
  // Analog sensing.
  input wire logic [3:0] i_short_to_gnd,
  input wire logic [3:0] i_short_to_pwr,
  input wire logic [1:0] i_dc_imbalance,
  input wire logic [3:0] i_overcurrent,
  input wire logic i_pwm_frame,
  input wire logic i_heat_warning,
  input wire logic i_thermal_shutdown,
  input wire logic i_supply_low_guard,
  input wire logic [3:0] i_bootstrap_node_low,
  // Alert pins, open drain, enable high drives low.
  output logic o_fault_n_out,
  output logic o_fault_n_oe,
  output logic o_clip_heat_warning_n_out,
  output logic o_clip_heat_warning_n_oe,
  // Power stage control: enable and high-side off per half bridge, shared ramp and pull-downs, check busy.
  output logic [3:0] o_bridge_enable,
  output logic [3:0] o_high_side_off,
  output logic o_ramp_down,
  output logic o_pulldown_enable,
  output logic o_pulldown_weak,
  output logic o_psc_busy
);

  // ----------------------------------------------------------------------
  // Mode decode and state
  // ----------------------------------------------------------------------
  afs_state_e state_reg, state_next;
  logic [31:0] cnt_reg, cnt_next;
  logic [7:0] ovl_cnt_reg [4];
  logic [3:0] ch_off_reg;
  logic thermal_latch_reg, reset_n_q_reg;
  wire mode_se = (i_out_mode == `AFS_MODE_SE);
  wire mode_paralleled_bridge_mode = (i_out_mode == `AFS_MODE_PARALLELED_BRIDGE_MODE);
  wire reset_rise = i_reset_n & ~reset_n_q_reg; // [R22]
  wire reset_fall = ~i_reset_n & reset_n_q_reg;
  wire any_short = |i_short_to_gnd | |i_short_to_pwr;
  wire dc_check_en = ~mode_se & ~mode_paralleled_bridge_mode; // [R2]
  wire clk_stuck = i_slave_clock_mode & i_external_switch_clock_slow; // [R18]
  wire in_psc = (state_reg == AFS_PSC_GND) || (state_reg == AFS_PSC_PWR);

  // Channel pair sharing one bridged output: A+B for 0/1, C+D for 2/3.
  function automatic logic [3:0] pair_mask(input logic [3:0] hit);
    pair_mask = {{2{hit[3] | hit[2]}}, {2{hit[1] | hit[0]}}};
  endfunction : pair_mask

  // ----------------------------------------------------------------------
  // Startup sequence and reset handling
  // ----------------------------------------------------------------------
  // Power-up goes to the short check once, or directly to hold in SE.
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    case (state_reg)
      AFS_POR: begin
        cnt_next = 32'h0;
        state_next = mode_se ? AFS_HOLD : AFS_PSC_GND; // [R3] [R9]
      end
      AFS_PSC_GND: begin
        if (|i_short_to_gnd) begin
          cnt_next = 32'h0; // [R4]
        end else if (cnt_reg >= PSC_STEP_CYC - 1) begin
          cnt_next = 32'h0;
          state_next = AFS_PSC_PWR; // [R5]
        end else begin
          cnt_next = cnt_reg + 32'h1; // [R6]
        end
      end
      AFS_PSC_PWR: begin
        if (|i_short_to_pwr) begin
          cnt_next = 32'h0; // [R4]
        end else if (cnt_reg >= PSC_STEP_CYC - 1) begin
          cnt_next = 32'h0;
          state_next = AFS_HOLD; // [R5]
        end else begin
          cnt_next = cnt_reg + 32'h1; // [R6]
        end
      end
      AFS_HOLD: begin
        // Wait for reset high; a later reset never returns to the check.
        if (i_reset_n) begin
          state_next = AFS_RUN; // [R8]
        end
      end
      AFS_RUN: begin
        if (reset_fall) begin
          cnt_next = 32'h0;
          state_next = AFS_RAMP; // [R20]
        end
      end
      AFS_RAMP: begin
        if (cnt_reg >= RAMP_CYC - 1) begin
          state_next = AFS_HOLD; // [R20]
        end else begin
          cnt_next = cnt_reg + 32'h1;
        end
      end
      default: state_next = AFS_POR;
    endcase
  end

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      state_reg <= AFS_POR;
      cnt_reg <= 32'h0;
      reset_n_q_reg <= 1'b1; // Idle level, so no false edge follows the power-on clear.
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      reset_n_q_reg <= in_psc ? reset_n_q_reg : i_reset_n; // [R7]
    end
  end

  // ----------------------------------------------------------------------
  // Overload counters and channel latches
  // ----------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_ch
      wire dc_hit = dc_check_en & i_dc_imbalance[g / 2]; // [R1] [R2]
      wire at_max = (ovl_cnt_reg[g] == `AFS_OVL_MAX);
      // Count up on overcurrent, down on clean frames, saturate on DC hit.
      always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
          ovl_cnt_reg[g] <= 8'h00; // [R13]
        end else if (dc_hit) begin
          ovl_cnt_reg[g] <= `AFS_OVL_MAX; // [R1]
        end else if (reset_rise) begin
          ovl_cnt_reg[g] <= 8'h00; // [R22]
        end else if (i_overcurrent[g] && !at_max) begin
          ovl_cnt_reg[g] <= ovl_cnt_reg[g] + 8'h01;
        end else if (i_pwm_frame && !i_overcurrent[g] && ovl_cnt_reg[g] != 8'h00 && !at_max) begin
          ovl_cnt_reg[g] <= ovl_cnt_reg[g] - 8'h01;
        end
      end
    end
  endgenerate

  wire [3:0] ovl_hit = {ovl_cnt_reg[3] == `AFS_OVL_MAX, ovl_cnt_reg[2] == `AFS_OVL_MAX,
                        ovl_cnt_reg[1] == `AFS_OVL_MAX, ovl_cnt_reg[0] == `AFS_OVL_MAX};
  // Paralleled mode shuts all four, otherwise only the affected pair.
  wire [3:0] ch_off_set = mode_paralleled_bridge_mode ? {4{|ovl_hit}} : pair_mask(ovl_hit); // [R15]

  // Latched faults; a thermal event on the reset edge still sets.
  // A DC hit on that edge re-latches one cycle later through its counter.
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      ch_off_reg <= 4'h0; // [R13]
      thermal_latch_reg <= 1'b0;
    end else begin
      ch_off_reg <= reset_rise ? 4'h0 : (ch_off_reg | ch_off_set); // [R22]
      thermal_latch_reg <= (thermal_latch_reg & ~reset_rise) | i_thermal_shutdown; // [R11] [R14]
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  wire running = (state_reg == AFS_RUN);
  wire ramping = (state_reg == AFS_RAMP);
  wire global_off = thermal_latch_reg | i_supply_low_guard | clk_stuck; // [R11] [R12] [R14] [R18]
  wire fault_cond = thermal_latch_reg | i_supply_low_guard | (|ch_off_reg) | in_psc;
  wire fault_low = fault_cond & (in_psc | i_reset_n); // [R7] [R16]
  // Bridges switch in run and through the ramp-down; global faults and shorts stop them all.
  wire [3:0] bridge_en = {4{(running | ramping) & ~global_off & ~any_short}} & ~ch_off_reg; // [R4] [R15] [R20]
  wire pd_en = ~i_reset_n & ~in_psc & ~ramping;

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_fault_n_oe <= 1'b0;
      o_clip_heat_warning_n_oe <= 1'b0;
      o_bridge_enable <= 4'h0;
      o_high_side_off <= 4'h0;
      o_ramp_down <= 1'b0;
      o_pulldown_enable <= 1'b0;
      o_pulldown_weak <= 1'b0;
      o_psc_busy <= 1'b0;
    end else begin
      o_fault_n_oe <= fault_low; // [R7] [R12] [R14]
      o_clip_heat_warning_n_oe <= i_heat_warning; // [R10] [R19]
      o_bridge_enable <= bridge_en; // [R20]
      o_high_side_off <= i_bootstrap_node_low; // [R24]
      o_ramp_down <= ramping; // [R20]
      o_pulldown_enable <= pd_en; // [R21]
      o_pulldown_weak <= pd_en & ~mode_se; // [R21]
      o_psc_busy <= in_psc;
    end
  end

  assign o_fault_n_out = 1'b0;
  assign o_clip_heat_warning_n_out = 1'b0;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  property p_psc_alert;
    @(posedge i_mclk) disable iff (!i_nrst) in_psc |=> o_fault_n_oe;
  endproperty
  a_psc_alert: assert property (p_psc_alert) else $error("alert not low during check"); // [R7]

  property p_reset_forces_high;
    @(posedge i_mclk) disable iff (!i_nrst) (!i_reset_n && !in_psc) |=> !o_fault_n_oe;
  endproperty
  a_reset_forces_high: assert property (p_reset_forces_high) else $error("alert low in reset"); // [R16]

  property p_warning;
    @(posedge i_mclk) disable iff (!i_nrst) i_heat_warning |=> o_clip_heat_warning_n_oe;
  endproperty
  a_warning: assert property (p_warning) else $error("warning not driven"); // [R10]

  property p_thermal_off;
    @(posedge i_mclk) disable iff (!i_nrst) i_thermal_shutdown |=> ##1 (o_bridge_enable == 4'h0);
  endproperty
  a_thermal_off: assert property (p_thermal_off) else $error("bridges on after shutdown"); // [R11]

  property p_supply_low;
    @(posedge i_mclk) disable iff (!i_nrst)
      i_supply_low_guard && i_reset_n |=> o_fault_n_oe && o_bridge_enable == 4'h0;
  endproperty
  a_supply_low: assert property (p_supply_low) else $error("supply low not handled"); // [R12]

  property p_se_no_check;
    @(posedge i_mclk) disable iff (!i_nrst) (state_reg == AFS_POR && mode_se) |=> !in_psc;
  endproperty
  a_se_no_check: assert property (p_se_no_check) else $error("check ran in single ended"); // [R9]

  property p_no_recheck;
    @(posedge i_mclk) disable iff (!i_nrst) !in_psc && $past(state_reg) != AFS_POR |=> !in_psc;
  endproperty
  a_no_recheck: assert property (p_no_recheck) else $error("check restarted"); // [R8]

  property p_step_order;
    @(posedge i_mclk) disable iff (!i_nrst)
      state_reg == AFS_PSC_PWR && $past(state_reg) != AFS_PSC_PWR |-> $past(state_reg) == AFS_PSC_GND;
  endproperty
  a_step_order: assert property (p_step_order) else $error("supply step before ground"); // [R5]

  property p_bootstrap;
    @(posedge i_mclk) disable iff (!i_nrst) i_bootstrap_node_low[0] |=> o_high_side_off[0];
  endproperty
  a_bootstrap: assert property (p_bootstrap) else $error("high side not off"); // [R24]

  property p_stuck_hiz;
    @(posedge i_mclk) disable iff (!i_nrst) clk_stuck |=> o_bridge_enable == 4'h0;
  endproperty
  a_stuck_hiz: assert property (p_stuck_hiz) else $error("bridges on with stuck clock"); // [R18]

  property p_channel_only;
    @(posedge i_mclk) disable iff (!i_nrst)
      running && !global_off && !any_short |=> o_bridge_enable == ~$past(ch_off_reg);
  endproperty
  a_channel_only: assert property (p_channel_only) else $error("healthy channel stopped"); // [R15]

  property p_reset_clears;
    @(posedge i_mclk) disable iff (!i_nrst) reset_rise |=> ch_off_reg == 4'h0;
  endproperty
  a_reset_clears: assert property (p_reset_clears) else $error("channel latch kept after reset"); // [R22]

  property p_warning_clears;
    @(posedge i_mclk) disable iff (!i_nrst) !i_heat_warning |=> !o_clip_heat_warning_n_oe;
  endproperty
  a_warning_clears: assert property (p_warning_clears) else $error("warning stuck"); // [R19]

endmodule : afs_supervisor
`default_nettype wire

/* File: hw/afs_defines.svh */
/*
  Constants for the amplifier fault supervisor: timing counts and mode codes.
  Assumes a 125 MHz core clock.
*/
`ifndef AFS_DEFINES_SVH
`define AFS_DEFINES_SVH
`define AFS_CLK_MHZ 125
`define AFS_PSC_MS_PER_UF 15
`define AFS_PSC_STEP_CYC ((`AFS_PSC_MS_PER_UF * 1000 * `AFS_CLK_MHZ) / 2)
`define AFS_RAMP_US 100
`define AFS_RAMP_CYC (`AFS_RAMP_US * `AFS_CLK_MHZ)
`define AFS_OVL_MAX 8'hFF
`define AFS_MODE_BTL 2'h0
`define AFS_MODE_PARALLELED_BRIDGE_MODE 2'h1
`define AFS_MODE_SE 2'h2
`endif

/* File: hw/afs_pkg.sv */
/*
  Types for the amplifier fault supervisor.
  Assumes afs_defines.svh is compiled alongside.
*/
`default_nettype none
package afs_pkg;
  typedef enum logic [2:0] {
    AFS_POR = 3'b000,
    AFS_PSC_GND = 3'b001,
    AFS_PSC_PWR = 3'b010,
    AFS_RUN = 3'b011,
    AFS_RAMP = 3'b100,
    AFS_HOLD = 3'b101
  } afs_state_e;
endpackage : afs_pkg
`default_nettype wire

/* File: bench/afs_host_model.sv */
/*
  Controller model that drives the reset pin of the supervisor.
  Assumes alert pins are open drain with pull-ups resolved by the bench.
*/
`default_nettype none
module afs_host_model #(
  parameter int unsigned GAP_CYC = 30,
  parameter int unsigned LOW_CYC = 20
) (
  // Clock.
  input wire logic i_mclk,
  // Alert pins and restart request.
  input wire logic i_fault_n,
  input wire logic i_clip_heat_warning_n,
  input wire logic i_restart,
  // Reset pin and status.
  output logic o_reset_n,
  output logic o_busy
);
  timeunit 1ns;
  timeprecision 1ps;
  int unsigned since_fall = 0;
  logic fault_q = 1'b1;
  // Counts cycles since the alert pin last fell.
  always @(posedge i_mclk) begin
    fault_q <= i_fault_n;
    if (fault_q && !i_fault_n) since_fall <= 0;
    else if (since_fall < GAP_CYC) since_fall <= since_fall + 1;
  end
  // Pulses reset low, then raises it only when safe to restart.
  initial begin
    o_reset_n = 1'b1;
    o_busy = 1'b0;
    forever begin
      @(posedge i_mclk);
      if (i_restart) begin
        @(negedge i_mclk);
        o_busy = 1'b1;
        o_reset_n = 1'b0;
        repeat (LOW_CYC) @(negedge i_mclk);
        // Waits out the alert gap and the warning; a hang here falls to the 3000-cycle loop limit in the bench's restart_dev.
        while (!(since_fall >= GAP_CYC && i_clip_heat_warning_n)) begin
          @(negedge i_mclk);
        end
        o_reset_n = 1'b1;
        o_busy = 1'b0;
      end
    end
  end
endmodule : afs_host_model
`default_nettype wire

/* File: bench/afs_supervisor_bench.sv */
/*
  Self-checking bench of the fault supervisor.
  Assumes short counts of 20 and 10 cycles set through parameters.
*/
`default_nettype none
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g); end end
module afs_supervisor_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_mclk = 0, i_nrst = 0, rst_n, restart = 0, hbusy;
  logic slave = 0, slow = 0, pwm = 0, heat = 0, therm = 0, supply_low_guard = 0;
  logic [1:0] mode = 2'h0, dc = 2'h0;
  logic [3:0] sg = 4'h1, sp = 4'h0, oc = 4'h0, bst = 4'h0, en, hso;
  logic f_out, f_oe, w_out, w_oe, ramp, pd, pdw, busy;
  logic s_ramp, s_pd, s_fh, s_psc, s_weak;
  int n_mismatch = 0, checks = 0, t;
  // Open-drain pins with pull-ups.
  wire fault_n = f_oe ? f_out : 1'b1;
  wire warn_n = w_oe ? w_out : 1'b1;
  always #4 i_mclk = ~i_mclk;
  afs_supervisor #(.PSC_STEP_CYC(20), .RAMP_CYC(10)) u_afs_supervisor (.i_mclk(i_mclk), .i_nrst(i_nrst),
    .i_reset_n(rst_n), .i_out_mode(mode), .i_slave_clock_mode(slave), .i_external_switch_clock_slow(slow),
    .i_short_to_gnd(sg), .i_short_to_pwr(sp), .i_dc_imbalance(dc), .i_overcurrent(oc), .i_pwm_frame(pwm),
    .i_heat_warning(heat), .i_thermal_shutdown(therm), .i_supply_low_guard(supply_low_guard),
    .i_bootstrap_node_low(bst), .o_fault_n_out(f_out), .o_fault_n_oe(f_oe), .o_clip_heat_warning_n_out(w_out),
    .o_clip_heat_warning_n_oe(w_oe), .o_bridge_enable(en), .o_high_side_off(hso), .o_ramp_down(ramp),
    .o_pulldown_enable(pd), .o_pulldown_weak(pdw), .o_psc_busy(busy));
  afs_host_model u_afs_host_model (.i_mclk(i_mclk), .i_fault_n(fault_n), .i_clip_heat_warning_n(warn_n),
    .i_restart(restart), .o_reset_n(rst_n), .o_busy(hbusy));
  // Waits whole cycles, ending on a falling edge.
  task automatic cyc(input int n);
    repeat (n) @(negedge i_mclk);
  endtask : cyc
  // Asks the controller for a reset cycle and records what the pins did.
  task automatic restart_dev();
    int k;
    s_ramp = 0;
    s_pd = 0;
    s_weak = 0;
    s_fh = 1;
    s_psc = 0;
    restart = 1;
    cyc(2);
    restart = 0;
    for (k = 0; k < 3000 && hbusy === 1'b1; k++) begin
      if (!rst_n && k > 3) begin
        s_ramp |= ramp;
        s_pd |= pd;
        s_weak |= pdw;
        s_fh &= !f_oe;
      end
      s_psc |= busy;
      cyc(1);
    end
    if (k >= 3000) n_mismatch++;
    cyc(4);
  endtask : restart_dev
  // Prints the counts and the verdict, then ends the run.
  task automatic stop_test();
    $display("checks %0d n_mismatch %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : stop_test
  // Watchdog.
  initial begin
    #300000;
    n_mismatch++;
    stop_test();
  end
  // Test sequence.
  initial begin
    cyc(5);
    i_nrst = 1;
    cyc(60);
    `CHK("psc busy", 1'b1, busy)
    `CHK("fault in check", 1'b1, f_oe)
    `CHK("bridges shorted", 4'h0, en)
    sg = 4'h0;
    for (t = 0; t < 200 && busy === 1'b1; t++) cyc(1);
    `CHK("check length", 1'b1, t >= 36 && t <= 46)
    cyc(4);
    `CHK("fault after check", 1'b0, f_oe)
    `CHK("alert pin low level", 1'b0, f_out | w_out)
    `CHK("bridges run", 4'hF, en)
    $display("test startup done");
    heat = 1;
    cyc(3);
    `CHK("warn on", 1'b1, w_oe)
    `CHK("bridges warm", 4'hF, en)
    heat = 0;
    cyc(3);
    `CHK("warn off", 1'b0, w_oe)
    bst = 4'h5;
    cyc(3);
    `CHK("high side off", 4'h5, hso)
    `CHK("fault boot", 1'b0, f_oe)
    bst = 4'h0;
    supply_low_guard = 1;
    cyc(3);
    `CHK("bridges uvp", 4'h0, en)
    `CHK("fault uvp", 1'b1, f_oe)
    supply_low_guard = 0;
    slave = 1;
    slow = 1;
    cyc(4);
    `CHK("bridges slow", 4'h0, en)
    `CHK("fault slow", 1'b0, f_oe)
    slow = 0;
    cyc(4);
    `CHK("bridges back", 4'hF, en)
    slave = 0;
    $display("test self clearing done");
    dc = 2'h1;
    cyc(4);
    dc = 2'h0;
    cyc(3);
    `CHK("bridges dc", 4'hC, en)
    `CHK("fault dc", 1'b1, f_oe)
    restart_dev();
    `CHK("bridges reset", 4'hF, en)
    `CHK("ramp seen", 1'b1, s_ramp)
    `CHK("pulldown seen", 1'b1, s_pd)
    `CHK("pulldown weak", 1'b1, s_weak)
    `CHK("fault forced high", 1'b1, s_fh)
    `CHK("no new check", 1'b0, s_psc)
    mode = 2'h1;
    dc = 2'h1;
    cyc(4);
    `CHK("bridges paralleled_bridge_mode dc", 4'hF, en)
    dc = 2'h0;
    mode = 2'h0;
    $display("test channel done");
    oc = 4'h4;
    cyc(200);
    oc = 4'h0;
    pwm = 1;
    cyc(210);
    pwm = 0;
    oc = 4'h4;
    cyc(200);
    `CHK("overload decays", 4'hF, en)
    cyc(70);
    `CHK("overload channel", 4'h3, en)
    `CHK("fault overload", 1'b1, f_oe)
    oc = 4'h0;
    restart_dev();
    `CHK("overload cleared", 4'hF, en)
    `CHK("fault overload cleared", 1'b0, f_oe)
    $display("test overload done");
    heat = 1;
    therm = 1;
    cyc(4);
    `CHK("bridges hot", 4'h0, en)
    `CHK("fault hot", 1'b1, f_oe)
    therm = 0;
    heat = 0;
    cyc(3);
    `CHK("thermal latched", 4'h0, en)
    restart_dev();
    `CHK("bridges cool", 4'hF, en)
    `CHK("fault cool", 1'b0, f_oe)
    $display("test thermal done");
    mode = 2'h2;
    i_nrst = 0;
    cyc(5);
    i_nrst = 1;
    cyc(4);
    `CHK("se no check", 1'b0, busy)
    `CHK("se run", 4'hF, en)
    dc = 2'h1;
    cyc(4);
    `CHK("se dc ignored", 4'hF, en)
    dc = 2'h0;
    restart_dev();
    `CHK("se pulldown", 1'b1, s_pd)
    `CHK("se pulldown strong", 1'b0, s_weak)
    $display("test single ended done");
    stop_test();
  end
endmodule : afs_supervisor_bench
`default_nettype wire
